/* File: rai_alarm_match.sv */
// one alarm comparator with per-field don't-care masking
`default_nettype none
module rai_alarm_match
    import rai_pkg::*;
(
    // inputs
    input  wire rai_time_s  now_in,
    input  wire rai_alarm_s alarm_in,
    // result
    output logic            match_out
);
    logic [RAI_NUM_FIELDS-1:0] field_eq;

    always_comb
    begin
        field_eq[0] = (now_in.seconds == alarm_in.value.seconds) | alarm_in.dont_care[0]; // [RQ7]
        field_eq[1] = (now_in.minutes == alarm_in.value.minutes) | alarm_in.dont_care[1]; // [RQ7]
        field_eq[2] = (now_in.hours   == alarm_in.value.hours)   | alarm_in.dont_care[2]; // [RQ7]
        field_eq[3] = (now_in.day     == alarm_in.value.day)     | alarm_in.dont_care[3]; // [RQ7]
        match_out   = &field_eq; // [RQ6]
    end
endmodule
`default_nettype wire

/* File: rai_host_model.sv */
// host side model: pulled-up interrupt inputs of the processor
`default_nettype none
module rai_host_m (
    input  wire logic p_oe_in, s_oe_in,
    output logic      p_pin_out, s_pin_out
);
    timeunit 1ns; timeprecision 1ns;
    // the pull-up wins whenever nobody sinks the line
    assign p_pin_out = p_oe_in ? 1'b0 : 1'b1;
    assign s_pin_out = s_oe_in ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

/* File: rai_irq_out.sv */
// two open-drain alarm interrupt outputs with routing of the primary output
`default_nettype none

// Functional notes
// RQ1 - A mode input selects whether the primary output follows alarm 0 alone or either alarm.
// RQ2 - The secondary output follows alarm 1 only and never alarm 0.
// RQ3 - Each output is a level held while the alarm flag and its enable are both set.
// RQ4 - Both outputs are active low open drain, pulling low when active and released otherwise.
// RQ5 - The paths run from the always-on timekeeping clock, so they work on any supply.
// RQ6 - An alarm flag is set when current time matches the programmed seconds, minutes, hours, day.
// RQ7 - Any alarm field can be marked don't-care and is then ignored in the match.
// RQ8 - Each output asserts as the OR over routed alarms of flag AND enable, driving the pin low.
module rai_irq_out
    import rai_pkg::*;
(
    // clock and reset (timekeeping domain)
    input  wire logic                      clk_in,
    input  wire logic                      rst_n_in,
    // time and alarm setup
    input  wire rai_time_s                 now_in,
    input  wire rai_alarm_s                alarm0_in,
    input  wire rai_alarm_s                alarm1_in,
    input  wire logic [RAI_NUM_ALARMS-1:0] irq_en_in,
    input  wire logic [RAI_NUM_ALARMS-1:0] flag_clr_in,
    input  wire logic                      prim_both_in,
    // status and pins
    output logic [RAI_NUM_ALARMS-1:0]      flag_out,
    output logic                           alarm_irq_primary_n_out,
    output logic                           alarm_irq_primary_oe_out,
    output logic                           alarm_irq_secondary_n_out,
    output logic                           alarm_irq_secondary_oe_out
);
    // ==========================================
    // match detection
    // raw 8-bit field compares; the time source owns the 12/24-hour and
    // BCD coding, so alarm and time must be written in the same format
    // a match lasts only while the time holds; the flags below keep it
    logic [RAI_NUM_ALARMS-1:0] match;

    rai_alarm_match u_match0
    (
        .now_in    (now_in),
        .alarm_in  (alarm0_in),
        .match_out (match[0])
    );

    rai_alarm_match u_match1
    (
        .now_in    (now_in),
        .alarm_in  (alarm1_in),
        .match_out (match[1])
    );

    // ==========================================
    // state
    // all registers of the block live in st_r, st_nxt is their next value;
    // the pins are registered so that comparator glitches never reach the
    // host's interrupt inputs
    rai_state_s                st_r;
    rai_state_s                st_nxt;

    // ==========================================
    // helper terms
    // live: flag and enable per alarm; route_*: alarms allowed onto a pin
    logic [RAI_NUM_ALARMS-1:0] live;
    logic [RAI_NUM_ALARMS-1:0] route_prim;
    logic [RAI_NUM_ALARMS-1:0] route_sec;
    logic                      prim_act;
    logic                      sec_act;

    // ==========================================
    // next state
    always_comb
    begin
        // defaults: hold the flags and pins, no pin activity
        st_nxt     = st_r;
        live       = '0;
        route_prim = '0;
        route_sec  = '0;
        prim_act   = 1'h0;
        sec_act    = 1'h0;

        // ==========================================
        // sticky alarm flags
        // set wins over a clear in the same cycle, so an alarm that fires
        // while software clears the previous one is never lost; a clear
        // held high keeps the flag low only while no match comes
        for (int i = 0; i < RAI_NUM_ALARMS; i++)
        begin
            case ({match[i], flag_clr_in[i]})
                2'h0:
                begin
                    st_nxt.hit[i] = st_r.hit[i];
                end
                2'h1:
                begin
                    st_nxt.hit[i] = 1'h0;
                end
                2'h2,
                2'h3:
                begin
                    st_nxt.hit[i] = 1'h1; // [RQ6]
                end
                default:
                begin
                    st_nxt.hit[i] = st_r.hit[i];
                end
            endcase
        end

        // ==========================================
        // live alarms
        // an alarm is live while its flag and its enable are both set;
        // the pins follow the registered flag, one cycle behind it
        for (int i = 0; i < RAI_NUM_ALARMS; i++)
        begin
            live[i] = st_r.hit[i] & irq_en_in[i]; // [RQ3]
        end

        // ==========================================
        // routing masks
        // the secondary mask is the same in both modes: alarm 0 never reaches it
        case (prim_both_in)
            1'h0:
            begin
                route_prim = 2'h1; // [RQ1]
                route_sec  = 2'h2; // [RQ2]
            end
            1'h1:
            begin
                route_prim = 2'h3; // [RQ1]
                route_sec  = 2'h2; // [RQ2]
            end
            default:
            begin
                // an unknown mode falls back to the narrower routing
                route_prim = 2'h1;
                route_sec  = 2'h2;
            end
        endcase

        // ==========================================
        // pin activity: any routed alarm that is live
        prim_act = |(live & route_prim); // [RQ8]
        sec_act  = |(live & route_sec);  // [RQ8]

        // ==========================================
        // open-drain drive
        // the enable is what sinks the line; the data copy is a low-active
        // mirror for logic that reads the pin state directly
        case (prim_act)
            1'h1:
            begin
                st_nxt.prim_n  = ~RAI_PIN_IDLE; // [RQ4]
                st_nxt.prim_oe = 1'h1;          // [RQ4]
            end
            1'h0:
            begin
                st_nxt.prim_n  = RAI_PIN_IDLE;
                st_nxt.prim_oe = 1'h0;
            end
            default:
            begin
                // unknown activity leaves the line released
                st_nxt.prim_n  = RAI_PIN_IDLE;
                st_nxt.prim_oe = 1'h0;
            end
        endcase

        case (sec_act)
            1'h1:
            begin
                st_nxt.sec_n  = ~RAI_PIN_IDLE; // [RQ4]
                st_nxt.sec_oe = 1'h1;          // [RQ4]
            end
            1'h0:
            begin
                st_nxt.sec_n  = RAI_PIN_IDLE;
                st_nxt.sec_oe = 1'h0;
            end
            default:
            begin
                // unknown activity leaves the line released
                st_nxt.sec_n  = RAI_PIN_IDLE;
                st_nxt.sec_oe = 1'h0;
            end
        endcase
    end

    // ==========================================
    // registers
    // no power-domain gating here: clk_in is the always-on timekeeping
    // oscillator, so flags and pins keep running on backup supply
    always_ff @(posedge clk_in or negedge rst_n_in) // [RQ5]
    begin
        if (!rst_n_in)
        begin
            // both lines released; the host pull-ups show the idle level
            st_r.hit     <= '0;
            st_r.prim_n  <= RAI_PIN_IDLE;
            st_r.prim_oe <= 1'h0;
            st_r.sec_n   <= RAI_PIN_IDLE;
            st_r.sec_oe  <= 1'h0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ==========================================
    // outputs, straight from the state register
    // sticky status
    assign flag_out                   = st_r.hit;

    // open-drain pins and their enables
    assign alarm_irq_primary_n_out    = st_r.prim_n;
    assign alarm_irq_primary_oe_out   = st_r.prim_oe;
    assign alarm_irq_secondary_n_out  = st_r.sec_n;
    assign alarm_irq_secondary_oe_out = st_r.sec_oe;
endmodule
`default_nettype wire

/* File: rai_irq_props.sv */
// concurrent checks on the alarm interrupt pins
`default_nettype none
module rai_irq_props import rai_pkg::*; (
    input wire logic       clk_in, rst_n_in, prim_both_in,
    input wire rai_time_s  now_in,
    input wire rai_alarm_s alarm0_in, alarm1_in,
    input wire logic [1:0] irq_en_in, flag_clr_in, flag_out,
    input wire logic       alarm_irq_primary_n_out, alarm_irq_primary_oe_out,
    input wire logic       alarm_irq_secondary_n_out, alarm_irq_secondary_oe_out
);
    timeunit 1ns; timeprecision 1ns;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence shared_s; flag_out[1] && irq_en_in[1] && prim_both_in; endsequence
    prim_route_a: assert property (alarm_irq_primary_oe_out ==
        $past(flag_out[0] & irq_en_in[0] | prim_both_in & flag_out[1] & irq_en_in[1]))
        else $error("primary pin wrong");
    sec_route_a: assert property (alarm_irq_secondary_oe_out ==
        $past(flag_out[1] & irq_en_in[1])) else $error("secondary pin wrong");
    shared_mode_a: assert property (shared_s |=> !alarm_irq_primary_n_out)
        else $error("shared mode missed");
    prim_pol_a: assert property (alarm_irq_primary_n_out == !alarm_irq_primary_oe_out)
        else $error("primary polarity wrong");
    sec_pol_a: assert property (alarm_irq_secondary_n_out == !alarm_irq_secondary_oe_out)
        else $error("secondary polarity wrong");
    flag_hold_a: assert property ($past(flag_out & ~flag_clr_in) ==
        (flag_out & $past(flag_out & ~flag_clr_in))) else $error("flag dropped");
    flag_fall_a: assert property ($fell(flag_out[0]) |-> $past(flag_clr_in[0]))
        else $error("flag fell without clear");
    idle_pins_a: assert property (flag_out == 2'h0 |=> !alarm_irq_primary_oe_out &&
        !alarm_irq_secondary_oe_out) else $error("pin active without flag");
endmodule
`default_nettype wire

/* File: rai_pkg.sv */
// package for the rtc alarm interrupt output block
`default_nettype none
package rai_pkg;
    // ==========================================
    // alarm field layout (seconds, minutes, hours, day)
    localparam int RAI_NUM_ALARMS   = 2;
    localparam int RAI_FIELD_W      = 8;
    localparam int RAI_NUM_FIELDS   = 4;
    localparam logic RAI_PIN_IDLE   = 1'b1;
    localparam logic RAI_MODE_RST   = 1'b0;

    typedef struct packed {
        logic [RAI_FIELD_W-1:0] day;
        logic [RAI_FIELD_W-1:0] hours;
        logic [RAI_FIELD_W-1:0] minutes;
        logic [RAI_FIELD_W-1:0] seconds;
    } rai_time_s;

    typedef struct packed {
        rai_time_s                 value;
        logic [RAI_NUM_FIELDS-1:0] dont_care;
    } rai_alarm_s;

    typedef struct packed {
        logic [RAI_NUM_ALARMS-1:0] hit;
        logic                      prim_n;
        logic                      prim_oe;
        logic                      sec_n;
        logic                      sec_oe;
    } rai_state_s;
endpackage
`default_nettype wire

/* File: tb_top.sv */
// self-checking bench for the alarm interrupt pins
`default_nettype none
module tb_top import rai_pkg::*;;
    timeunit 1ns; timeprecision 1ns;
    logic clk_in = 0, rst_n_in = 0, prim_both_in = RAI_MODE_RST, po, poe, so, soe, pp, sp, ep, es;
    rai_time_s now_in = '0;
    rai_alarm_s alarm0_in = '0, alarm1_in = '0;
    logic [1:0] irq_en_in = '0, flag_clr_in = '0, flag_out, ef;
    int n_errors = 0, samples_checked = 0, cyc = 0;
    rai_irq_out dut_u (.clk_in, .rst_n_in, .now_in, .alarm0_in, .alarm1_in, .irq_en_in,
        .flag_clr_in, .prim_both_in, .flag_out, .alarm_irq_primary_n_out(po),
        .alarm_irq_primary_oe_out(poe), .alarm_irq_secondary_n_out(so),
        .alarm_irq_secondary_oe_out(soe));
    rai_host_m host_u (.p_oe_in(poe), .s_oe_in(soe), .p_pin_out(pp), .s_pin_out(sp));
    function automatic logic mt(rai_time_s t, rai_alarm_s a);
        mt = 1'b1;
        for (int f = 0; f < RAI_NUM_FIELDS; f++)
            if (!a.dont_care[f] && a.value[8*f+:8] !== t[8*f+:8]) mt = 1'b0;
    endfunction
    task automatic chk(string nm, logic [1:0] e, logic [1:0] s);
        samples_checked++;
        if (s !== e) begin n_errors++; $display("ERROR %s expected %b seen %b", nm, e, s); end
    endtask
    task automatic conclude();
        if (n_errors == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial forever #25 clk_in = ~clk_in;
    // model: pins follow last cycle's flags, set wins over clear
    always @(posedge clk_in or negedge rst_n_in)
        if (!rst_n_in) {ef, ep, es} = '0;
        else
        begin
            ep = ef[0] & irq_en_in[0] | prim_both_in & ef[1] & irq_en_in[1];
            es = ef[1] & irq_en_in[1];
            ef = {mt(now_in, alarm1_in), mt(now_in, alarm0_in)} | ef & ~flag_clr_in;
        end
    always @(negedge clk_in)
    begin
        chk("flags", ef, flag_out);
        chk("primary", {!ep, ep}, {po, poe});
        chk("secondary", {!es, es}, {so, soe});
        chk("pin levels", {!ep, !es}, {pp, sp});
        cyc++;
        if (cyc > 3000) begin n_errors++; conclude(); end
    end
    // fields limited to 0 or 1 so that matches come often
    initial
    begin
        void'($urandom(26));
        repeat (10) @(posedge clk_in);
        repeat (2)
        begin
            rst_n_in <= 1'b1;
            repeat (1200) @(posedge clk_in)
            begin
                now_in <= $urandom & 32'h01010101;
                alarm0_in <= {$urandom & 32'h01010101, 4'($urandom)};
                alarm1_in <= {$urandom & 32'h01010101, 4'($urandom)};
                irq_en_in <= 2'($urandom);
                flag_clr_in <= 2'($urandom & $urandom);
                prim_both_in <= 1'($urandom);
            end
            rst_n_in <= 1'b0;
            repeat (3) @(posedge clk_in);
        end
        conclude();
    end
endmodule
bind rai_irq_out rai_irq_props chk_u (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .prim_both_in(prim_both_in), .now_in(now_in),
    .alarm0_in(alarm0_in), .alarm1_in(alarm1_in), .irq_en_in(irq_en_in),
    .flag_clr_in(flag_clr_in), .flag_out(flag_out),
    .alarm_irq_primary_n_out(alarm_irq_primary_n_out),
    .alarm_irq_primary_oe_out(alarm_irq_primary_oe_out),
    .alarm_irq_secondary_n_out(alarm_irq_secondary_n_out),
    .alarm_irq_secondary_oe_out(alarm_irq_secondary_oe_out));
`default_nettype wire
